// *** design/mps_pkg.sv ***
// Purpose: Shared constants for the multiport switch
// Assumes: Three masters, three slaves, 32-bit paths
// Notes: Address windows are plain defaults
package mps_pkg;
	localparam int NUM_MASTERS = 3;
	localparam int NUM_SLAVES = 3;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int PRIO_W = 2;
	localparam int ID_W = 2;
	// Master identifiers
	localparam logic [ID_W-1:0] M_IFETCH = 2'h0;
	localparam logic [ID_W-1:0] M_LDST = 2'h1;
	localparam logic [ID_W-1:0] M_DMA = 2'h2;
	// Slave identifiers
	localparam logic [ID_W-1:0] S_FLASH = 2'h0;
	localparam logic [ID_W-1:0] S_SRAM = 2'h1;
	localparam logic [ID_W-1:0] S_BRIDGE = 2'h2;
	localparam logic [ID_W-1:0] S_NONE = 2'h3;
	// Decode on top address nibble
	localparam logic [3:0] FLASH_REGION = 4'h0;
	localparam logic [3:0] SRAM_REGION = 4'h4;
	localparam logic [3:0] BRIDGE_REGION = 4'hC;
	// Default fixed priorities, higher wins
	localparam logic [PRIO_W-1:0] PRIO_IFETCH = 2'h1;
	localparam logic [PRIO_W-1:0] PRIO_LDST = 2'h1;
	localparam logic [PRIO_W-1:0] PRIO_DMA = 2'h0;
	localparam logic [PRIO_W-1:0] PRIO_ELEVATED = 2'h3;
	localparam logic [ID_W-1:0] LAST_RESET = 2'h2;
endpackage : mps_pkg

// *** design/mps_decode.sv ***
// Purpose: Address to slave port decoder
// Assumes: Region in top address nibble
// Notes: Unmapped addresses select no slave
`timescale 1ns/1ps
`default_nettype none
module mps_decode (
	input wire logic [mps_pkg::ADDR_W-1:0] addr_in,
	output logic [mps_pkg::ID_W-1:0] slave_out
);
	import mps_pkg::*;
	always_comb begin
		if (addr_in[31:28] == FLASH_REGION) begin
			slave_out = S_FLASH;
		end else if (addr_in[31:28] == SRAM_REGION) begin
			slave_out = S_SRAM;
		end else if (addr_in[31:28] == BRIDGE_REGION) begin
			slave_out = S_BRIDGE;
		end else begin
			slave_out = S_NONE;
		end
	end
endmodule : mps_decode
`default_nettype wire

// *** design/mps_slave_arb.sv ***
// Purpose: Arbiter owning one slave port
// Assumes: Requests held until the transfer completes
// Notes: Owner kept until its request drops, with or without done
`timescale 1ns/1ps
`default_nettype none
module mps_slave_arb (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [mps_pkg::NUM_MASTERS-1:0] req_in,
	input wire logic [mps_pkg::NUM_MASTERS*mps_pkg::PRIO_W-1:0] prio_in,
	input wire logic [mps_pkg::NUM_MASTERS-1:0] block_in,
	input wire logic done_in,
	output logic busy_out,
	output logic [mps_pkg::ID_W-1:0] owner_out
);
	import mps_pkg::*;
	logic busy_reg;
	logic [ID_W-1:0] owner_reg;
	logic [ID_W-1:0] last_reg;
	logic [NUM_MASTERS-1:0] elig;
	logic pick_valid;
	logic [ID_W-1:0] pick;
	logic [PRIO_W-1:0] best_prio;
	logic [NUM_MASTERS-1:0] beaten;

	function automatic logic [ID_W-1:0] next_id(input logic [ID_W-1:0] id,
		input int step);
		int v;
		v = (int'(id) + step) % NUM_MASTERS;
		return v[ID_W-1:0];
	endfunction : next_id

	assign elig = req_in & ~block_in;

	// Highest priority first, ties after last grant
	always_comb begin
		logic [ID_W-1:0] c;
		logic [PRIO_W-1:0] p;
		c = '0;
		p = '0;
		pick_valid = 1'b0;
		pick = '0;
		best_prio = '0;
		for (int k = 1; k <= NUM_MASTERS; k++) begin
			c = next_id(last_reg, k); // RQ6
			p = prio_in[c*PRIO_W +: PRIO_W];
			if (elig[c] && (!pick_valid || p > best_prio)) begin // RQ4 RQ9
				pick_valid = 1'b1;
				pick = c;
				best_prio = p;
			end
		end
	end

	// Any eligible master above the chosen level
	always_comb begin
		for (int k = 0; k < NUM_MASTERS; k++) begin
			beaten[k] = elig[k] && prio_in[k*PRIO_W +: PRIO_W] > best_prio;
		end
	end

	// Ownership held, others stall until release
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			busy_reg <= 1'b0; // RQ11
			owner_reg <= '0;
			last_reg <= LAST_RESET;
		end else if (busy_reg) begin
			if (done_in && !req_in[owner_reg]) begin // RQ5
				busy_reg <= 1'b0;
			end else if (!req_in[owner_reg]) begin
				busy_reg <= 1'b0;
			end
		end else if (pick_valid) begin
			busy_reg <= 1'b1;
			owner_reg <= pick;
			last_reg <= pick; // RQ6
		end
	end

	assign busy_out = busy_reg;
	assign owner_out = owner_reg;

	a_free_after_reset: assert property (@(posedge clock_in) // RQ11
		rst_in |=> !busy_reg)
		else $error("slave port owned after reset");
	a_owner_requests: assert property (@(posedge clock_in) // RQ5
		disable iff (rst_in) busy_reg && req_in[owner_reg] |=>
		busy_reg && owner_reg == $past(owner_reg))
		else $error("ownership lost while owner still requesting");
	a_grant_highest: assert property (@(posedge clock_in) // RQ4
		disable iff (rst_in) !busy_reg && pick_valid |->
		elig[pick] && beaten == '0 ##1
		busy_reg && owner_reg == $past(pick))
		else $error("grant went to a lower priority master");
endmodule : mps_slave_arb
`default_nettype wire

// *** design/mps_multiport_switch.sv ***
// Purpose: Three master by three slave multiport switch
// Assumes: Masters hold request and address until ready
// Notes: Single clock, synchronous reset
// Operation
// RQ1: Three master and three slave ports with parallel distinct paths.
// RQ2: Every port carries 32-bit address and 32-bit data.
// RQ3: At most two transfers in flight, one an instruction fetch to flash.
// RQ4: Contending masters on one slave go to the higher priority one.
// RQ5: Losing masters stall until the owner finishes on that slave.
// RQ6: Equal priority masters rotate after the last granted identifier.
// RQ7: Masters are instruction fetch, load/store data and the DMA master.
// RQ8: Slaves are flash memory, on-chip SRAM and the peripheral bridge.
// RQ9: Each master port has its own fixed priority level.
// RQ10: A master's priority may be raised temporarily and then falls back.
// RQ11: Arbitration state is clocked and cleared by reset, no owner after.
// RQ12: Fixed priorities and the elevation source are parameters.
`timescale 1ns/1ps
`default_nettype none
module mps_multiport_switch #(
	parameter logic [mps_pkg::PRIO_W-1:0] PRIO_M0 = mps_pkg::PRIO_IFETCH,
	parameter logic [mps_pkg::PRIO_W-1:0] PRIO_M1 = mps_pkg::PRIO_LDST,
	parameter logic [mps_pkg::PRIO_W-1:0] PRIO_M2 = mps_pkg::PRIO_DMA,
	parameter bit ELEV_EXTERNAL = 1'b1
) (
	input wire logic clock_in,
	input wire logic rst_in,
	// Master requests: 0 fetch, 1 load/store, 2 DMA
	input wire logic [mps_pkg::NUM_MASTERS-1:0] m_req_in,
	input wire logic [mps_pkg::NUM_MASTERS-1:0] m_write_in,
	input wire logic [mps_pkg::NUM_MASTERS*mps_pkg::ADDR_W-1:0] m_addr_in,
	input wire logic [mps_pkg::NUM_MASTERS*mps_pkg::DATA_W-1:0] m_wdata_in,
	input wire logic [mps_pkg::NUM_MASTERS-1:0] m_elevate_in,
	output logic [mps_pkg::NUM_MASTERS-1:0] m_ready_out,
	output logic [mps_pkg::NUM_MASTERS-1:0] m_error_out,
	output logic [mps_pkg::NUM_MASTERS*mps_pkg::DATA_W-1:0] m_rdata_out,
	// Slave ports: 0 flash, 1 SRAM, 2 peripheral bridge
	output logic [mps_pkg::NUM_SLAVES-1:0] s_sel_out,
	output logic [mps_pkg::NUM_SLAVES-1:0] s_write_out,
	output logic [mps_pkg::NUM_SLAVES*mps_pkg::ADDR_W-1:0] s_addr_out,
	output logic [mps_pkg::NUM_SLAVES*mps_pkg::DATA_W-1:0] s_wdata_out,
	input wire logic [mps_pkg::NUM_SLAVES-1:0] s_ready_in,
	input wire logic [mps_pkg::NUM_SLAVES*mps_pkg::DATA_W-1:0] s_rdata_in
);
	import mps_pkg::*;

	logic [ID_W-1:0] m_target [NUM_MASTERS];
	logic [NUM_MASTERS*PRIO_W-1:0] prio_now;
	logic [NUM_SLAVES-1:0] s_busy;
	logic [ID_W-1:0] s_owner [NUM_SLAVES];
	logic [NUM_MASTERS-1:0] s_reqs [NUM_SLAVES];
	logic [NUM_MASTERS-1:0] s_block [NUM_SLAVES];
	logic [NUM_SLAVES-1:0] s_done;
	logic [NUM_MASTERS-1:0] ready_reg;
	logic [NUM_MASTERS-1:0] error_reg;
	logic [NUM_MASTERS*DATA_W-1:0] rdata_reg;
	logic [NUM_MASTERS-1:0] elev_reg;
	logic non_fetch_active;
	logic [ID_W-1:0] nf_slot;

	function automatic logic [PRIO_W-1:0] base_prio(input int m);
		if (m == int'(M_IFETCH)) begin
			return PRIO_M0;
		end else if (m == int'(M_LDST)) begin
			return PRIO_M1;
		end
		return PRIO_M2;
	endfunction : base_prio

	// Masters that would take the single non-fetch slot on slave s
	function automatic logic [NUM_MASTERS-1:0] nf_mask(input int s);
		logic [NUM_MASTERS-1:0] r;
		r = '1;
		if (s == int'(S_FLASH)) begin
			r[M_IFETCH] = 1'b0;
		end
		return r;
	endfunction : nf_mask

	// Elevation is registered so it ends cleanly on the next cycle
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			elev_reg <= '0;
		end else begin
			elev_reg <= ELEV_EXTERNAL ? m_elevate_in : '0; // RQ12
		end
	end

	// Fixed level per master, raised while elevated
	always_comb begin
		for (int m = 0; m < NUM_MASTERS; m++) begin
			prio_now[m*PRIO_W +: PRIO_W] = elev_reg[m] ?
				PRIO_ELEVATED : base_prio(m); // RQ9 RQ10
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_MASTERS; g++) begin : g_dec
			mps_decode u_dec (
				.addr_in(m_addr_in[g*ADDR_W +: ADDR_W]),
				.slave_out(m_target[g])
			);
		end
	endgenerate

	// Only one non-fetch-to-flash transfer may own a port
	always_comb begin
		non_fetch_active = 1'b0;
		for (int s = 0; s < NUM_SLAVES; s++) begin
			if (s_busy[s] && !(s == int'(S_FLASH) &&
				s_owner[s] == M_IFETCH)) begin
				non_fetch_active = 1'b1;
			end
		end
	end

	always_comb begin
		for (int s = 0; s < NUM_SLAVES; s++) begin
			for (int m = 0; m < NUM_MASTERS; m++) begin
				s_reqs[s][m] = m_req_in[m] && m_target[m] == s[ID_W-1:0];
			end
			s_done[s] = s_busy[s] && s_ready_in[s] && !ready_reg[s_owner[s]];
		end
	end

	// Same-cycle requests on two free slaves would both win otherwise
	always_comb begin
		nf_slot = S_NONE;
		for (int s = NUM_SLAVES - 1; s >= 0; s--) begin
			if (!s_busy[s] && (s_reqs[s] & nf_mask(s)) != '0) begin
				nf_slot = s[ID_W-1:0];
			end
		end
		for (int s = 0; s < NUM_SLAVES; s++) begin
			s_block[s] = (non_fetch_active || nf_slot != s[ID_W-1:0]) ?
				nf_mask(s) : '0; // RQ3
		end
	end

	generate
		for (g = 0; g < NUM_SLAVES; g++) begin : g_arb
			mps_slave_arb u_arb (
				.clock_in(clock_in),
				.rst_in(rst_in),
				.req_in(s_reqs[g]),
				.prio_in(prio_now),
				.block_in(s_block[g]),
				.done_in(s_done[g]),
				.busy_out(s_busy[g]),
				.owner_out(s_owner[g])
			);
		end
	endgenerate

	// Route owner onto each slave port independently
	always_comb begin
		for (int s = 0; s < NUM_SLAVES; s++) begin
			s_sel_out[s] = s_busy[s] && m_req_in[s_owner[s]] &&
				!ready_reg[s_owner[s]]; // RQ1 RQ8
			s_write_out[s] = m_write_in[s_owner[s]];
			s_addr_out[s*ADDR_W +: ADDR_W] =
				m_addr_in[s_owner[s]*ADDR_W +: ADDR_W]; // RQ2
			s_wdata_out[s*DATA_W +: DATA_W] =
				m_wdata_in[s_owner[s]*DATA_W +: DATA_W];
		end
	end

	// Answers registered back to the owning master
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			ready_reg <= '0;
			error_reg <= '0;
			rdata_reg <= '0;
		end else begin
			ready_reg <= '0;
			error_reg <= '0;
			for (int m = 0; m < NUM_MASTERS; m++) begin
				if (m_req_in[m] && !ready_reg[m] && m_target[m] == S_NONE) begin
					ready_reg[m] <= 1'b1;
					error_reg[m] <= 1'b1;
				end
			end
			for (int s = 0; s < NUM_SLAVES; s++) begin
				if (s_done[s]) begin // RQ5
					ready_reg[s_owner[s]] <= 1'b1; // RQ7
					rdata_reg[s_owner[s]*DATA_W +: DATA_W] <=
						s_rdata_in[s*DATA_W +: DATA_W];
				end
			end
		end
	end

	assign m_ready_out = ready_reg;
	assign m_error_out = error_reg;
	assign m_rdata_out = rdata_reg;

	a_two_in_flight: assert property (@(posedge clock_in) // RQ3
		disable iff (rst_in) $countones(s_busy) == 2 |->
		s_busy[S_FLASH] && s_owner[S_FLASH] == M_IFETCH)
		else $error("second transfer is not a flash fetch");
	a_max_two_busy: assert property (@(posedge clock_in) // RQ3
		disable iff (rst_in) $countones(s_busy) <= 2)
		else $error("more than two transfers in flight");
	a_elev_ends: assert property (@(posedge clock_in) // RQ10
		disable iff (rst_in) !m_elevate_in[M_DMA] |=>
		prio_now[M_DMA*PRIO_W +: PRIO_W] == PRIO_M2)
		else $error("elevated priority did not fall back");
	a_sel_by_owner: assert property (@(posedge clock_in) // RQ1
		disable iff (rst_in) s_sel_out[S_SRAM] |->
		m_target[s_owner[S_SRAM]] == S_SRAM)
		else $error("slave selected for foreign master");
	a_done_ready: assert property (@(posedge clock_in) // RQ5
		disable iff (rst_in) s_done[S_SRAM] |=> m_ready_out[$past(s_owner[S_SRAM])])
		else $error("owner not answered after slave ready");
endmodule : mps_multiport_switch
`default_nettype wire

// *** verification/mps_slave_model.sv ***
// Purpose: Flash, SRAM and bridge slaves facing the switch
// Assumes: Each slave answers after one wait state
// Notes: Data is a junk pattern outside a completion
`timescale 1ns/1ps
`default_nettype none
module mps_slave_model (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [2:0] sel_in,
	input wire logic [95:0] addr_in,
	output logic [2:0] ready_out,
	output logic [95:0] rdata_out
);
	logic [31:0] junk_reg;
	always_ff @(posedge clock_in) begin
		junk_reg <= rst_in ? 32'h0 : junk_reg + 32'h01010101;
		for (int k = 0; k < 3; k++) begin
			// Wait state keeps the grant visible a full cycle
			ready_out[k] <= !rst_in && sel_in[k] && !ready_out[k];
			rdata_out[k*32+:32] <= (sel_in[k] && !ready_out[k]) ?
				addr_in[k*32+:32] ^ 32'h5A5A5A5A : ~junk_reg;
		end
	end
endmodule : mps_slave_model
`default_nettype wire

// *** verification/tb_mps_multiport_switch.sv ***
// Purpose: Self-checking bench for the multiport switch
// Assumes: Slave model with one wait state
// Notes: Writes exercised only on the SRAM port by t_write, write inputs otherwise low
`timescale 1ns/1ps
`default_nettype none
module tb_mps_multiport_switch;
	import mps_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [2:0] req = 3'h0;
	logic [2:0] elev = 3'h0;
	logic [95:0] addr = 96'h0;
	logic [2:0] wr = 3'h0;
	logic [95:0] wd = 96'h0;
	logic [2:0] rdy, err, sel, srdy, swr;
	logic [95:0] rdata, saddr, swd, srd;
	int bad_count = 0;
	int n_tests = 0;
	int done_q[$];
	always #10 clock = ~clock;
	mps_multiport_switch mps_multiport_switch_i (.clock_in(clock),
		.rst_in(rst), .m_req_in(req), .m_write_in(wr),
		.m_addr_in(addr), .m_wdata_in(wd), .m_elevate_in(elev),
		.m_ready_out(rdy), .m_error_out(err), .m_rdata_out(rdata),
		.s_sel_out(sel), .s_write_out(swr), .s_addr_out(saddr),
		.s_wdata_out(swd), .s_ready_in(srdy), .s_rdata_in(srd));
	mps_slave_model mps_slave_model_i (.clock_in(clock), .rst_in(rst),
		.sel_in(sel), .addr_in(saddr), .ready_out(srdy), .rdata_out(srd));
	task automatic complete_run();
		$display("compares %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// One whole transfer; request held until the ready pulse
	task automatic xfer(input int m, input logic [31:0] a,
		output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(negedge clock);
		addr[m*32+:32] = a;
		req[m] = 1'b1;
		do begin
			@(posedge clock);
			#1 n++;
		end while (rdy[m] !== 1'b1 && n < 60);
		if (rdy[m] !== 1'b1) begin
			bad_count++;
			complete_run();
		end
		rd = rdata[m*32+:32];
		er = err[m];
		done_q.push_back(m);
		@(negedge clock);
		req[m] = 1'b0;
	endtask : xfer
	// Two masters at once; first finisher and a select pattern watched
	task automatic race(input int m1, input logic [31:0] a1, input int m2,
		input logic [31:0] a2, output int first, output logic both);
		logic [31:0] d1, d2;
		logic e1, e2;
		done_q.delete();
		both = 1'b0;
		fork
			xfer(m1, a1, d1, e1);
			xfer(m2, a2, d2, e2);
			repeat (12) begin
				@(posedge clock);
				#2 if ($countones(sel) > 1) both = 1'b1;
			end
		join
		first = done_q[0];
		chk(d1, a1 ^ 32'h5A5A5A5A);
		chk(d2, a2 ^ 32'h5A5A5A5A);
	endtask : race
	task automatic t_reset();
		chk({29'h0, sel}, 32'h0);
		chk({29'h0, rdy | err}, 32'h0);
		chk(rdata[31:0] | rdata[63:32] | rdata[95:64], 32'h0);
	endtask : t_reset
	task automatic t_single();
		logic [31:0] rd;
		logic er;
		logic [31:0] base [3] = '{32'h0000_0104, 32'h4000_0208,
			32'hC000_030C};
		for (int m = 0; m < 3; m++) begin
			xfer(m, base[m], rd, er);
			chk(rd, base[m] ^ 32'h5A5A5A5A);
			chk({31'h0, er}, 32'h0);
		end
		xfer(2, 32'h8000_0010, rd, er);
		chk({31'h0, er}, 32'h1);
	endtask : t_single
	task automatic t_arb();
		int f;
		logic b;
		race(0, 32'h4000_0020, 1, 32'h4000_0024, f, b);
		chk(f, 0);
		race(2, 32'h4000_0030, 1, 32'h4000_0034, f, b);
		chk(f, 1);
		@(negedge clock);
		elev[2] = 1'b1;
		race(1, 32'h4000_0040, 2, 32'h4000_0044, f, b);
		chk(f, 2);
		@(negedge clock);
		elev[2] = 1'b0;
		race(2, 32'h4000_0050, 1, 32'h4000_0054, f, b);
		chk(f, 1);
	endtask : t_arb
	task automatic t_par();
		int f;
		logic b;
		race(0, 32'h0000_0060, 1, 32'h4000_0064, f, b);
		chk({31'h0, b}, 32'h1);
		race(1, 32'h4000_0070, 2, 32'hC000_0074, f, b);
		chk({31'h0, b}, 32'h0);
	endtask : t_par
	// Write routed to the SRAM port while the grant stands
	task automatic t_write();
		logic [31:0] rd;
		logic er;
		@(negedge clock);
		wr[1] = 1'b1;
		wd[63:32] = 32'hA5C3_0F96;
		fork
			xfer(1, 32'h4000_0080, rd, er);
			begin
				@(negedge clock);
				@(posedge clock);
				#2 chk({30'h0, sel[1], swr[1]}, 32'h3);
				chk(swd[63:32], 32'hA5C3_0F96);
				chk(saddr[63:32], 32'h4000_0080);
			end
		join
		chk({31'h0, er}, 32'h0);
		@(negedge clock);
		wr[1] = 1'b0;
	endtask : t_write
	initial begin
		repeat (16) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		t_reset();
		t_arb();
		t_single();
		t_write();
		t_par();
		complete_run();
	end
endmodule : tb_mps_multiport_switch
`default_nettype wire
